// ### hdl/fpdr_map.vh
`ifndef FPDR_MAP_VH
`define FPDR_MAP_VH

// opcodes
`define FPDR_OP_WAKE        8'hab
`define FPDR_OP_SLEEP       8'hb9
`define FPDR_OP_RDSR        8'h05
`define FPDR_OP_SUSPEND     8'h75
`define FPDR_OP_RESUME      8'h7a
`define FPDR_OP_PAGE_PROG   8'h02
`define FPDR_OP_SECT_ERASE  8'h20
`define FPDR_OP_BIG_ERASE   8'hd8
`define FPDR_OP_WRR         8'h01
`define FPDR_OP_OTP_PROG    8'h42
`define FPDR_OP_LRN_PROG    8'h43
`define FPDR_OP_PROT_PROG   8'h2f
`define FPDR_OP_PASS_PROG   8'he8
`define FPDR_OP_PPB_PROG    8'he3
`define FPDR_OP_PPB_ERASE   8'he4
`define FPDR_OP_EES         8'hd0
`define FPDR_OP_PARAM_READ  8'h5a
`define FPDR_OP_ID_READ     8'h9f

// parameter space layout (byte addresses)
`define FPDR_PS_HEADER      16'h0000
`define FPDR_PS_ID_REGION   16'h1000
`define FPDR_PS_CFI_ENTRY   16'h108e
`define FPDR_PS_STD_TABLE   16'h1090
`define FPDR_PS_AW          16

// busy flag position in the volatile status register
`define FPDR_SR_BUSY_BIT    0

// times as printed, then 50 MHz cycle counts (exact products, nothing rounds)
`define FPDR_CLK_MHZ        50
`define FPDR_T_WAKE_US      30
`define FPDR_T_SL_US        50
`define FPDR_T_PP_US        2000
`define FPDR_T_W_MS         750
`define FPDR_T_SE4K_MS      725
`define FPDR_T_SE256K_MS    2900
`define FPDR_T_EES_US       100
`define FPDR_CYC_WAKE       (`FPDR_T_WAKE_US * `FPDR_CLK_MHZ)
`define FPDR_CYC_SL         (`FPDR_T_SL_US * `FPDR_CLK_MHZ)
`define FPDR_CYC_PP         (`FPDR_T_PP_US * `FPDR_CLK_MHZ)
`define FPDR_CYC_W          (`FPDR_T_W_MS * 1000 * `FPDR_CLK_MHZ)
`define FPDR_CYC_SE4K       (`FPDR_T_SE4K_MS * 1000 * `FPDR_CLK_MHZ)
`define FPDR_CYC_SE256K     (`FPDR_T_SE256K_MS * 1000 * `FPDR_CLK_MHZ)
`define FPDR_CYC_EES        (`FPDR_T_EES_US * `FPDR_CLK_MHZ)
`define FPDR_CNT_W          32

`endif

// ### hdl/fpdr_sync.v
`timescale 1ns/1ps
// two-flop synchroniser per bit
module fpdr_sync #(
	parameter W = 7
) (
	// clock and reset
	input  wire         clock,
	input  wire         rst,
	// async in, sync out
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clock or posedge rst) begin
				if (rst) begin
					meta_ff[i] <= 1'b0;
					sync_ff[i] <= 1'b0;
				end else begin
					meta_ff[i] <= async_in[i];
					sync_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate
	assign sync_out = sync_ff;
endmodule // fpdr_sync

// ### hdl/fpdr_seq.v
`timescale 1ns/1ps
`include "fpdr_map.vh"
// Behaviour
// - wake opcode ABh between chip-select edges
// - wake returns no identification data
// - no commands until wake wait ends
// - hardware reset leaves deepest sleep
// - suspend clears busy within 50 us
// - one-time programs take page write time
// - protect bit program/erase page/sector time
// - nv register write within 750 ms
// - 4 KB erase within 725 ms
// - 256 KB erase within 2900 ms
// - erase status check within 100 us
// - parameter space header at 0000h
// - identification region at 1000h
// - standard table 1090h, entry 108Eh
// - both read commands reach parameter space
// - sleeping device ignores all but wake
// - busy flag bit0, set while working
module fpdr_seq #(
	parameter [31:0] WAKE_CYC  = `FPDR_CYC_WAKE,
	parameter [31:0] SL_CYC    = `FPDR_CYC_SL,
	parameter [31:0] PP_CYC    = `FPDR_CYC_PP,
	parameter [31:0] W_CYC     = `FPDR_CYC_W,
	parameter [31:0] SE4K_CYC  = `FPDR_CYC_SE4K,
	parameter [31:0] SE256_CYC = `FPDR_CYC_SE256K,
	parameter [31:0] EES_CYC   = `FPDR_CYC_EES
) (
	// clock and reset
	input  wire        clock,
	input  wire        rst,
	// spi pins
	input  wire        cs_n,
	input  wire        sck,
	input  wire [3:0]  io_in,
	// mode
	input  wire        four_line_command_mode,
	// status
	output reg         sleeping,
	output reg         waking,
	output reg  [7:0]  volatile_status_register,
	output reg         cmd_valid,
	output reg  [7:0]  cmd_code,
	output reg         param_read_active,
	output reg  [15:0] param_base_addr
);
	localparam S_IDLE  = 2'h0;
	localparam S_SLEEP = 2'h1;
	localparam S_WAKE  = 2'h2;
	localparam S_BUSY  = 2'h3;

	wire [6:0] pins_s;
	fpdr_sync #(.W(7)) u_sync (
		.clock    (clock),
		.rst      (rst),
		// select goes through inverted so the flops' reset zero means idle high
		.async_in ({four_line_command_mode, io_in, sck, ~cs_n}),
		.sync_out (pins_s)
	);
	wire       cs_n_s = ~pins_s[0];
	wire       sck_s  = pins_s[1];
	wire [3:0] io_s   = pins_s[5:2];
	wire       qmode  = pins_s[6];

	reg         sck_d_ff;
	reg         cs_d_ff;
	reg  [7:0]  shift_ff;
	reg  [3:0]  nbit_ff;
	reg  [1:0]  state_ff;
	reg  [31:0] cnt_ff;
	reg  [31:0] susp_cnt_ff;
	reg  [1:0]  nxt_state;
	reg  [31:0] nxt_cnt;
	reg  [31:0] op_len;
	reg         op_known;

	wire sck_rise = sck_s & ~sck_d_ff;
	wire cs_rise  = cs_n_s & ~cs_d_ff;
	wire [3:0] step = qmode ? 4'h4 : 4'h1;
	wire [7:0] shifted = qmode ? {shift_ff[3:0], io_s} : {shift_ff[6:0], io_s[0]};
	// a command counts only if exactly eight bits arrived before deselect
	wire full_byte = (nbit_ff == 4'h8);

	// self-timed durations per opcode
	always @* begin
		op_known = 1'b1;
		case (shift_ff)
			`FPDR_OP_PAGE_PROG,
			`FPDR_OP_OTP_PROG,
			`FPDR_OP_LRN_PROG,
			`FPDR_OP_PROT_PROG,
			`FPDR_OP_PASS_PROG:  op_len = PP_CYC;
			`FPDR_OP_PPB_PROG:   op_len = PP_CYC;
			`FPDR_OP_PPB_ERASE:  op_len = SE4K_CYC;
			`FPDR_OP_WRR:        op_len = W_CYC;
			`FPDR_OP_SECT_ERASE: op_len = SE4K_CYC;
			`FPDR_OP_BIG_ERASE:  op_len = SE256_CYC;
			`FPDR_OP_EES:        op_len = EES_CYC;
			default: begin
				op_len   = 32'h0;
				op_known = 1'b0;
			end
		endcase
	end

	always @* begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			S_SLEEP: begin
				// only the wake opcode is honoured here
				if (cs_rise && full_byte && shift_ff == `FPDR_OP_WAKE) begin
					nxt_state = S_WAKE;
					nxt_cnt   = WAKE_CYC;
				end
			end
			S_WAKE: begin
				// decode is gated off; host must hold select high meanwhile
				if (cnt_ff <= 32'h1) begin
					nxt_state = S_IDLE;
					nxt_cnt   = 32'h0;
				end else begin
					nxt_cnt = cnt_ff - 32'h1;
				end
			end
			S_BUSY: begin
				if (cs_rise && full_byte && shift_ff == `FPDR_OP_SUSPEND) begin
					if (susp_cnt_ff == 32'h0 && cnt_ff > SL_CYC)
						nxt_cnt = SL_CYC;
				end
				if (cnt_ff <= 32'h1) begin
					nxt_state = S_IDLE;
					nxt_cnt   = 32'h0;
				end else begin
					nxt_cnt = (nxt_cnt == cnt_ff) ? cnt_ff - 32'h1 : nxt_cnt;
				end
			end
			S_IDLE: begin
				if (cs_rise && full_byte) begin
					if (shift_ff == `FPDR_OP_SLEEP) begin
						nxt_state = S_SLEEP;
					end else if (op_known) begin
						nxt_state = S_BUSY;
						nxt_cnt   = op_len;
					end
				end
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			// hardware reset always lands in idle, never asleep
			state_ff    <= S_IDLE;
			cnt_ff      <= 32'h0;
			susp_cnt_ff <= 32'h0;
			sck_d_ff    <= 1'b0;
			cs_d_ff     <= 1'b1;
			shift_ff    <= 8'h00;
			nbit_ff     <= 4'h0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			sck_d_ff <= sck_s;
			cs_d_ff  <= cs_n_s;
			susp_cnt_ff <= (susp_cnt_ff != 32'h0) ? susp_cnt_ff - 32'h1 : 32'h0;
			if (cs_n_s) begin
				nbit_ff <= 4'h0;
			end else if (sck_rise && nbit_ff < 4'h9) begin
				nbit_ff  <= nbit_ff + step;
				shift_ff <= shifted;
			end
		end
	end

	always @(posedge clock or posedge rst) begin
		if (rst) begin
			sleeping                 <= 1'b0;
			waking                   <= 1'b0;
			volatile_status_register <= 8'h00;
			cmd_valid                <= 1'b0;
			cmd_code                 <= 8'h00;
			param_read_active        <= 1'b0;
			param_base_addr          <= `FPDR_PS_HEADER;
		end else begin
			sleeping <= (nxt_state == S_SLEEP);
			waking   <= (nxt_state == S_WAKE);
			volatile_status_register[`FPDR_SR_BUSY_BIT] <= (nxt_state == S_BUSY);
			// decoded commands only leave while awake; the wake that ends sleep is not echoed
			cmd_valid <= cs_rise && full_byte && state_ff == S_IDLE;
			if (cs_rise && full_byte && state_ff != S_SLEEP && state_ff != S_WAKE)
				cmd_code <= shift_ff;
			if (cs_rise) begin
				param_read_active <= 1'b0;
			end else if (!cs_n_s && full_byte && state_ff == S_IDLE) begin
				// both reads open the same space; id read lands in id region
				if (shift_ff == `FPDR_OP_PARAM_READ) begin
					param_read_active <= 1'b1;
					param_base_addr   <= `FPDR_PS_HEADER;
				end else if (shift_ff == `FPDR_OP_ID_READ) begin
					param_read_active <= 1'b1;
					param_base_addr   <= `FPDR_PS_ID_REGION;
				end
			end
		end
	end
endmodule // fpdr_seq

// ### tb/fpdr_seq_assertions.sv
`timescale 1ns/1ps
module fpdr_chk #(
	parameter int WAKE_CYC = 20,
	parameter int SL_CYC   = 10,
	parameter int PP_CYC   = 50,
	parameter int W_CYC    = 100,
	parameter int SE4K_CYC = 100,
	parameter int SE256_CYC = 100,
	parameter int EES_CYC  = 20
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        sleeping,
	input wire logic        waking,
	input wire logic [7:0]  volatile_status_register,
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        param_read_active,
	input wire logic [15:0] param_base_addr
);
	localparam int SHI = SL_CYC + 4;
	localparam int BL1 = (PP_CYC > W_CYC) ? PP_CYC : W_CYC;
	localparam int BL2 = (SE4K_CYC > SE256_CYC) ? SE4K_CYC : SE256_CYC;
	localparam int BL3 = (BL1 > BL2) ? BL1 : BL2;
	localparam int BLIM = (BL3 > EES_CYC) ? BL3 : EES_CYC;
	// run lengths are counted, too long for a repetition
	int wake_run_ff;
	int busy_run_ff;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			wake_run_ff <= 0;
			busy_run_ff <= 0;
		end else begin
			wake_run_ff <= waking ? wake_run_ff + 1 : 0;
			busy_run_ff <= volatile_status_register[0] ? busy_run_ff + 1 : 0;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	status_bits_a: assert property (volatile_status_register[7:1] == 7'h00)
		else $error("status bits above busy set");
	sleep_mute_a: assert property (sleeping && $past(sleeping) |-> !cmd_valid && $stable(cmd_code))
		else $error("command taken while asleep");
	wait_mute_a: assert property (waking && $past(waking) |-> !cmd_valid)
		else $error("command taken during wake wait");
	wake_exit_a: assert property ($fell(sleeping) |-> waking && !param_read_active)
		else $error("wake did not start wait");
	wake_len_a: assert property ($fell(waking) |-> wake_run_ff == WAKE_CYC)
		else $error("wake wait length wrong");
	busy_max_a: assert property (busy_run_ff <= BLIM)
		else $error("busy too long");
	suspend_lat_a: assert property ($changed(cmd_code) && cmd_code == 8'h75 && volatile_status_register[0] |-> ##[0:SHI] !volatile_status_register[0])
		else $error("suspend latency exceeded");
	param_base_a: assert property ($rose(param_read_active) |-> param_base_addr == 16'h0000 || param_base_addr == 16'h1000)
		else $error("parameter base wrong");
endmodule // fpdr_chk

// ### tb/fpdr_host.sv
`timescale 1ns/1ps
module fpdr_host (
	// spi pins
	output logic       cs_n,
	output logic       sck,
	output logic [3:0] io
);
	initial begin
		cs_n = 1'b1;
		sck  = 1'b0;
		io   = 4'h5;
	end
	// sck stands low outside frames; keep leaves select low
	task automatic xfer(input logic [7:0] b, input logic quad, input logic keep);
		cs_n = 1'b0;
		for (int i = 0; i < (quad ? 2 : 8); i++) begin
			io = quad ? (i == 0 ? b[7:4] : b[3:0]) : {~io[3:1], b[7-i]};
			#80 sck = 1'b1;
			#80 sck = 1'b0;
		end
		if (!keep)
			close();
	endtask
	// released lines flip so stale data cannot pass
	task automatic close();
		cs_n = 1'b1;
		io   = ~io;
	endtask
endmodule // fpdr_host

// ### tb/flash_power_down_release_and_param_map_tb_top.sv
`timescale 1ns/1ps
module flash_power_down_release_and_param_map_tb_top;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        quad = 1'b0;
	wire         cs_n, sck;
	wire  [3:0]  io;
	logic        sleeping, waking, cmd_valid, pra;
	logic [7:0]  status, cmd_code;
	logic [15:0] base;
	int          fails = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [7:0]  ops[10] = '{8'h02, 8'h42, 8'h43, 8'h2f, 8'he8, 8'he3, 8'he4, 8'h20, 8'h01, 8'hd8};
	always #10 clock = ~clock;
	fpdr_host host (.cs_n(cs_n), .sck(sck), .io(io));
	fpdr_seq #(.SL_CYC(10), .PP_CYC(50), .W_CYC(100),
		.SE4K_CYC(100), .SE256_CYC(100)) uut (.clock(clock), .rst(rst),
		.cs_n(cs_n), .sck(sck), .io_in(io), .four_line_command_mode(quad),
		.sleeping(sleeping), .waking(waking), .volatile_status_register(status),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_read_active(pra),
		.param_base_addr(base));
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask
	task automatic send(input logic [7:0] b, input int gap);
		@(negedge clock);
		host.xfer(b, quad, 1'b0);
		repeat (gap) @(negedge clock);
	endtask
	task automatic count(input int len, input logic w, output int n);
		n = 0;
		repeat (len) begin
			@(negedge clock);
			n += w ? waking : status[0];
		end
	endtask
	task automatic t_sleep();
		logic [7:0] c;
		send(8'hb9, 6);
		c = cmd_code;
		send(8'h05, 0);
		send(8'h9f, 6);
		check(sleeping === 1'b1 && cmd_code === c && pra === 1'b0, "sleep not mute");
	endtask
	task automatic t_wake(input logic q);
		int n;
		quad = q;
		t_sleep();
		send(8'hab, 0);
		count(1600, 1'b1, n);
		check(sleeping === 1'b0 && n >= 1499 && n <= 1501, "wake wait wrong");
		check(pra === 1'b0, "wake gave data");
		quad = 1'b0;
	endtask
	task automatic t_busy();
		int n;
		for (int i = 0; i < 10; i++) begin
			send(ops[i], 0);
			count(130, 1'b0, n);
			check(n <= (i < 6 ? 50 : 100) && n >= (i < 6 ? 49 : 99), "busy length");
		end
		// erase status check keeps its full 100 us at 50 MHz
		send(8'hd0, 0);
		count(5100, 1'b0, n);
		check(n <= 5000 && n >= 4999, "erase status length");
	endtask
	task automatic t_suspend();
		int n;
		send(8'hd8, 10);
		check(status[0] === 1'b1, "erase not busy");
		send(8'h75, 0);
		count(40, 1'b0, n);
		check(n <= 14, "suspend slow");
	endtask
	task automatic t_param(input logic [7:0] op, input logic [15:0] a);
		@(negedge clock);
		host.xfer(op, 1'b0, 1'b1);
		repeat (6) @(negedge clock);
		check(pra === 1'b1 && base === a, "parameter base");
		host.close();
		repeat (6) @(negedge clock);
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(negedge clock);
		rst = 1'b0;
		check(sleeping === 1'b0 && waking === 1'b0 && status === 8'h00, "reset state");
		t_wake(1'b0);
		t_wake(1'b1);
		t_busy();
		t_suspend();
		t_param(8'h5a, 16'h0000);
		t_param(8'h9f, 16'h1000);
		t_sleep();
		rst = 1'b1;
		@(negedge clock);
		rst = 1'b0;
		check(sleeping === 1'b0, "reset kept sleep");
		test_done();
	end
endmodule // flash_power_down_release_and_param_map_tb_top
bind fpdr_seq fpdr_chk #(.WAKE_CYC(WAKE_CYC), .SL_CYC(SL_CYC), .PP_CYC(PP_CYC), .W_CYC(W_CYC),
	.SE4K_CYC(SE4K_CYC), .SE256_CYC(SE256_CYC), .EES_CYC(EES_CYC)) chk (.clock(clock), .rst(rst),
	.sleeping(sleeping), .waking(waking), .volatile_status_register(volatile_status_register),
	.cmd_valid(cmd_valid), .cmd_code(cmd_code), .param_read_active(param_read_active),
	.param_base_addr(param_base_addr));
